// ===== core/ufc_channel.v
// One UART channel: host registers, FIFOs, serial engines, ready pins
`timescale 1ns/1ps
`include "ufc_consts.vh"
module ufc_channel #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       resetn,
  // Host bus
  input  wire       cs_n,
  input  wire       rd_n,
  input  wire       wr_n,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  output wire [7:0] rdata,
  input  wire       ready_summary_select_n,
  input  wire [2:0] peer_rx_ready_n,
  input  wire [2:0] peer_tx_ready_n,
  // Serial and modem
  input  wire       rx,
  output wire       tx,
  input  wire       cts_n,
  output wire       rts_n,
  output wire       dtr_n,
  // Status pins
  output wire       irq,
  output wire       tx_ready_n,
  output wire       rx_ready_n,
  output wire       sleep_en
);
  localparam [3:0] S_IDLE = 4'h1, S_START = 4'h2, S_DATA = 4'h4, S_STOP = 4'h8;
  localparam [AW:0] ZERO = 0;
  reg [7:0]  rdata_ff, interrupt_mask_ff, line_format_control_ff;
  reg [7:0]  modem_control_ff, scratch_ff, enhanced_feature_control_ff;
  reg [7:0]  resume_char_low_ff, resume_char_high_ff;
  reg [7:0]  pause_char_low_ff, pause_char_high_ff;
  reg [15:0] div_ff;
  reg        fifo_en_ff, dma_mode_ff, rx_flush_ff, tx_flush_ff;
  reg [1:0]  rx_trig_ff, tx_trig_ff;
  reg        overrun_ff, line_int_ff, rts_int_ff, cts_int_ff, pause_int_ff;
  reg        rts_prev_ff, cts_prev_ff, rx_dma_ff;
  reg [6:0]  err_cnt_ff;
  reg [15:0] baud_ff;
  reg [3:0]  ts_ff, rs_ff;
  reg [3:0]  tt_ff, rt_ff;
  reg [2:0]  tb_ff, rb_ff;
  reg [7:0]  tx_shift_stage_ff, rx_shift_stage_ff;
  reg        tx_ff, rx_prev_ff;
  // Access decode
  wire wr  = ~cs_n & ~wr_n;
  wire rd  = ~cs_n & ~rd_n;
  wire enh = line_format_control_ff == `UFC_ENH_KEY;
  wire dla = line_format_control_ff[`UFC_DLAB_BIT] & ~enh;
  wire efe = enhanced_feature_control_ff[`UFC_FEAT_ENH];
  wire gen = ~enh & ~dla;
  // FIFO wires
  wire        txf_rdy, txf_val, rxf_rdy, rxf_val;
  wire [7:0]  txf_dat;
  wire [10:0] rxf_dat;
  wire [AW:0] txf_cnt, rxf_cnt;
  wire        thr_wr = wr & gen & (addr == `UFC_A_DATA);
  wire        rhr_rd = rd & gen & (addr == `UFC_A_DATA);
  wire        tx_take;
  wire        rx_push;
  wire [10:0] rx_word;
  ufc_fifo #(.W(8), .D(DEPTH), .AW(AW)) u_txf (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .flush     (tx_flush_ff),
    .one_deep  (~fifo_en_ff),
    .in_valid  (thr_wr),
    .in_ready  (txf_rdy),
    .in_data   (wdata),
    .out_valid (txf_val),
    .out_ready (tx_take),
    .out_data  (txf_dat),
    .count     (txf_cnt)
  );
  ufc_fifo #(.W(11), .D(DEPTH), .AW(AW)) u_rxf (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .flush     (rx_flush_ff),
    .one_deep  (~fifo_en_ff),
    .in_valid  (rx_push),
    .in_ready  (rxf_rdy),
    .in_data   (rx_word),
    .out_valid (rxf_val),
    .out_ready (rhr_rd),
    .out_data  (rxf_dat),
    .count     (rxf_cnt)
  );
  // Trigger levels
  reg [6:0] rx_lvl, tx_lvl;
  always @* begin
    case (rx_trig_ff)
      2'h0:    rx_lvl = `UFC_TRIG_8;
      2'h1:    rx_lvl = `UFC_TRIG_16;
      2'h2:    rx_lvl = `UFC_TRIG_56;
      default: rx_lvl = `UFC_TRIG_60;
    endcase
    case (tx_trig_ff)
      2'h0:    tx_lvl = `UFC_TRIG_8;
      2'h1:    tx_lvl = `UFC_TRIG_16;
      2'h2:    tx_lvl = `UFC_TRIG_32;
      default: tx_lvl = `UFC_TRIG_56;
    endcase
  end
  // Baud tick: divisor zero behaves as one
  wire tick = (baud_ff <= 16'h0001);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      baud_ff <= `UFC_RST_DIV;
    else if (tick)
      baud_ff <= div_ff;
    else
      baud_ff <= baud_ff - 16'h0001;
  end
  // Transmitter, fixed eight data bits and one stop bit
  assign tx_take = (ts_ff == S_IDLE) & txf_val;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ts_ff <= S_IDLE;
      tt_ff <= 4'h0;
      tb_ff <= 3'h0;
      tx_shift_stage_ff <= 8'h00;
      tx_ff <= 1'b1;
    end else begin
      case (ts_ff)
        S_IDLE: begin
          tx_ff <= 1'b1;
          if (txf_val) begin
            tx_shift_stage_ff <= txf_dat;
            ts_ff <= S_START;
            tt_ff <= 4'h0;
          end
        end
        S_START: begin
          tx_ff <= 1'b0;
          if (tick) begin
            tt_ff <= tt_ff + 4'h1;
            if (tt_ff == `UFC_TICKS_BIT) begin
              ts_ff <= S_DATA;
              tb_ff <= 3'h0;
              tx_ff <= tx_shift_stage_ff[0];
            end
          end
        end
        S_DATA: begin
          tx_ff <= tx_shift_stage_ff[0];
          if (tick) begin
            tt_ff <= tt_ff + 4'h1;
            if (tt_ff == `UFC_TICKS_BIT) begin
              tx_shift_stage_ff <= {1'b0, tx_shift_stage_ff[7:1]};
              tb_ff <= tb_ff + 3'h1;
              if (tb_ff == `UFC_DATA_BITS)
                ts_ff <= S_STOP;
            end
          end
        end
        S_STOP: begin
          tx_ff <= 1'b1;
          if (tick) begin
            tt_ff <= tt_ff + 4'h1;
            if (tt_ff == `UFC_TICKS_BIT)
              ts_ff <= S_IDLE;
          end
        end
        default: ts_ff <= S_IDLE;
      endcase
    end
  end
  // Receiver; stop-bit time rounds to the sample point
  wire rx_done = (rs_ff == S_STOP) & tick & (rt_ff == `UFC_TICKS_BIT);
  wire brk     = ~rx & (rx_shift_stage_ff == 8'h00);
  assign rx_word = {brk, ~rx, 1'b0, rx_shift_stage_ff};
  assign rx_push = rx_done;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rs_ff <= S_IDLE;
      rt_ff <= 4'h0;
      rb_ff <= 3'h0;
      rx_shift_stage_ff <= 8'h00;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx;
      case (rs_ff)
        S_IDLE: begin
          rt_ff <= 4'h0;
          if (rx_prev_ff & ~rx)
            rs_ff <= S_START;
        end
        S_START: if (tick) begin
          rt_ff <= rt_ff + 4'h1;
          if (rt_ff == `UFC_START_MID) begin
            rt_ff <= 4'h0;
            rb_ff <= 3'h0;
            rs_ff <= rx ? S_IDLE : S_DATA;
          end
        end
        S_DATA: if (tick) begin
          rt_ff <= rt_ff + 4'h1;
          if (rt_ff == `UFC_TICKS_BIT) begin
            rx_shift_stage_ff <= {rx, rx_shift_stage_ff[7:1]};
            rb_ff <= rb_ff + 3'h1;
            if (rb_ff == `UFC_DATA_BITS)
              rs_ff <= S_STOP;
          end
        end
        S_STOP: if (tick) begin
          rt_ff <= rt_ff + 4'h1;
          if (rt_ff == `UFC_TICKS_BIT)
            rs_ff <= S_IDLE;
        end
        default: rs_ff <= S_IDLE;
      endcase
    end
  end
  // Status terms
  wire rx_err_in  = rx_push & rxf_rdy & (rx_word[10] | rx_word[9]);
  wire rx_err_out = rhr_rd & rxf_val & (rxf_dat[10] | rxf_dat[9]);
  wire thr_empty  = fifo_en_ff ? txf_rdy : ~txf_val;
  wire all_empty  = ~txf_val & (ts_ff == S_IDLE);
  wire [7:0] lstat = {err_cnt_ff != 7'h00, all_empty, thr_empty,
                      rxf_val & rxf_dat[10], rxf_val & rxf_dat[9],
                      rxf_val & rxf_dat[8], overrun_ff, rxf_val};
  wire rx_trig  = fifo_en_ff ? (rxf_cnt >= rx_lvl) : rxf_val;
  wire tx_low   = (fifo_en_ff & dma_mode_ff) ?
                  (txf_cnt < tx_lvl) : thr_empty;
  // Interrupt sources; mask bits 0-3 and 5-7 all clear means polled use only
  wire i_line  = interrupt_mask_ff[2] & line_int_ff;
  wire i_rxd   = interrupt_mask_ff[0] & rx_trig;
  wire i_txe   = interrupt_mask_ff[1] & tx_low;
  wire i_pause = efe & interrupt_mask_ff[5] & pause_int_ff;
  wire i_flow  = efe & ((interrupt_mask_ff[6] & rts_int_ff) |
                        (interrupt_mask_ff[7] & cts_int_ff));
  reg [5:0] isr_code;
  always @* begin
    if (i_line)
      isr_code = `UFC_ISR_LINE;
    else if (i_rxd)
      isr_code = `UFC_ISR_RXD;
    else if (i_txe)
      isr_code = `UFC_ISR_TXE;
    else if (i_pause)
      isr_code = `UFC_ISR_PAUSE;
    else if (i_flow)
      isr_code = `UFC_ISR_FLOW;
    else
      isr_code = `UFC_ISR_NONE;
  end
  wire isr_rd = rd & ~dla & ~enh & (addr == `UFC_A_FIFO);
  wire lsr_rd = rd & gen & (addr == `UFC_A_LSTAT);
  // Read mux, captured into a register
  reg [7:0] rmux;
  always @* begin
    rmux = 8'h00;
    if (enh) begin
      case (addr)
        `UFC_A_FEAT:   rmux = enhanced_feature_control_ff;
        `UFC_A_RES_LO: rmux = resume_char_low_ff;
        `UFC_A_RES_HI: rmux = resume_char_high_ff;
        `UFC_A_PAU_LO: rmux = pause_char_low_ff;
        `UFC_A_PAU_HI: rmux = pause_char_high_ff;
        `UFC_A_FMT:    rmux = line_format_control_ff;
        default:       rmux = 8'h00;
      endcase
    end else if (dla && addr == `UFC_A_DATA)
      rmux = div_ff[7:0];
    else if (dla && addr == `UFC_A_MASK)
      rmux = div_ff[15:8];
    else begin
      case (addr)
        `UFC_A_DATA:    rmux = rxf_dat[7:0];
        `UFC_A_MASK:    rmux = interrupt_mask_ff;
        `UFC_A_FIFO:    rmux = {fifo_en_ff, fifo_en_ff,
                                efe ? isr_code[5:4] : 2'b00,
                                isr_code[3:0]};
        `UFC_A_FMT:     rmux = line_format_control_ff;
        `UFC_A_MODEM:   rmux = modem_control_ff;
        `UFC_A_LSTAT:   rmux = lstat;
        `UFC_A_MSTAT:   rmux = {3'b000, ~cts_n, 4'h0};
        `UFC_A_SCRATCH: rmux = scratch_ff;
        default:        rmux = 8'h00;
      endcase
    end
    if (~ready_summary_select_n)
      rmux = {peer_rx_ready_n, rx_ready_n,
              peer_tx_ready_n, tx_ready_n};
  end
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      rdata_ff <= 8'h00;
    else if (rd | (~ready_summary_select_n & ~rd_n))
      rdata_ff <= rmux;
  end
  // Register writes
  wire fcr_wr = wr & gen & (addr == `UFC_A_FIFO);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_mask_ff      <= `UFC_RST_REG;
      line_format_control_ff <= `UFC_RST_REG;
      modem_control_ff       <= `UFC_RST_REG;
      scratch_ff             <= `UFC_RST_SCR;
      enhanced_feature_control_ff <= `UFC_RST_REG;
      resume_char_low_ff  <= `UFC_RST_REG;
      resume_char_high_ff <= `UFC_RST_REG;
      pause_char_low_ff   <= `UFC_RST_REG;
      pause_char_high_ff  <= `UFC_RST_REG;
      div_ff      <= `UFC_RST_DIV;
      fifo_en_ff  <= 1'b0;
      dma_mode_ff <= 1'b0;
      rx_trig_ff  <= 2'h0;
      tx_trig_ff  <= 2'h0;
      rx_flush_ff <= 1'b0;
      tx_flush_ff <= 1'b0;
    end else begin
      rx_flush_ff <= 1'b0;
      tx_flush_ff <= 1'b0;
      if (wr && addr == `UFC_A_FMT)
        line_format_control_ff <= wdata;
      if (wr && enh) begin
        case (addr)
          `UFC_A_FEAT:   enhanced_feature_control_ff <= wdata;
          `UFC_A_RES_LO: resume_char_low_ff  <= wdata;
          `UFC_A_RES_HI: resume_char_high_ff <= wdata;
          `UFC_A_PAU_LO: pause_char_low_ff   <= wdata;
          `UFC_A_PAU_HI: pause_char_high_ff  <= wdata;
          default: ;
        endcase
      end
      if (wr && dla && addr == `UFC_A_DATA)
        div_ff[7:0] <= wdata;
      if (wr && dla && addr == `UFC_A_MASK)
        div_ff[15:8] <= wdata;
      if (wr && gen && addr == `UFC_A_MASK) begin
        interrupt_mask_ff[3:0] <= wdata[3:0];
        if (efe)
          interrupt_mask_ff[7:4] <= wdata[7:4];
      end
      if (wr && gen && addr == `UFC_A_MODEM) begin
        modem_control_ff[4:0] <= wdata[4:0];
        if (efe)
          modem_control_ff[7:5] <= wdata[7:5];
      end
      if (wr && gen && addr == `UFC_A_SCRATCH)
        scratch_ff <= wdata;
      if (fcr_wr) begin
        fifo_en_ff <= wdata[0];
        // Enable change flushes; flush bits count only with bit 0 set
        rx_flush_ff <= wdata[0] ^ fifo_en_ff;
        tx_flush_ff <= wdata[0] ^ fifo_en_ff;
        if (wdata[0]) begin
          rx_flush_ff <= wdata[1] | ~fifo_en_ff;
          tx_flush_ff <= wdata[2] | ~fifo_en_ff;
          dma_mode_ff <= wdata[3];
          rx_trig_ff  <= wdata[7:6];
          if (efe)
            tx_trig_ff <= wdata[5:4];
        end
      end
    end
  end
  // Sticky events: a set in the clearing cycle wins
  wire rts_lvl = modem_control_ff[1];
  wire pause_hit  = rx_push & (rx_word[7:0] == pause_char_low_ff);
  wire resume_hit = rx_push & (rx_word[7:0] == resume_char_low_ff);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      overrun_ff   <= 1'b0;
      line_int_ff  <= 1'b0;
      rts_int_ff   <= 1'b0;
      cts_int_ff   <= 1'b0;
      pause_int_ff <= 1'b0;
      rts_prev_ff  <= 1'b1;
      cts_prev_ff  <= 1'b1;
      err_cnt_ff   <= 7'h00;
      rx_dma_ff    <= 1'b0;
    end else begin
      rts_prev_ff <= rts_lvl;
      cts_prev_ff <= ~cts_n;
      if (rx_push & ~rxf_rdy)
        overrun_ff <= 1'b1;
      else if (lsr_rd)
        overrun_ff <= 1'b0;
      if (rx_push)
        line_int_ff <= 1'b1;
      else if (lsr_rd)
        line_int_ff <= 1'b0;
      if (~rts_prev_ff & rts_lvl)
        rts_int_ff <= 1'b1;
      else if (isr_rd)
        rts_int_ff <= 1'b0;
      if (~cts_prev_ff & ~cts_n)
        cts_int_ff <= 1'b1;
      else if (isr_rd)
        cts_int_ff <= 1'b0;
      if (pause_hit)
        pause_int_ff <= 1'b1;
      else if (resume_hit)
        pause_int_ff <= 1'b0;
      if (rx_flush_ff)
        err_cnt_ff <= 7'h00;
      else if (rx_err_in & ~rx_err_out)
        err_cnt_ff <= err_cnt_ff + 7'h01;
      else if (rx_err_out & ~rx_err_in)
        err_cnt_ff <= err_cnt_ff - 7'h01;
      if (rxf_cnt >= rx_lvl)
        rx_dma_ff <= 1'b1;
      else if (rxf_cnt == ZERO)
        rx_dma_ff <= 1'b0;
    end
  end
  // Outputs
  wire mode1 = fifo_en_ff & dma_mode_ff;
  assign tx_ready_n = mode1 ? ~txf_rdy : txf_val;
  assign rx_ready_n = mode1 ? ~rx_dma_ff : ~rxf_val;
  assign irq      = i_line | i_rxd | i_txe | i_pause | i_flow;
  assign rdata    = rdata_ff;
  assign tx       = tx_ff;
  assign rts_n    = ~rts_lvl;
  assign dtr_n    = ~modem_control_ff[0];
  assign sleep_en = efe & interrupt_mask_ff[4];
endmodule // ufc_channel

// ===== core/ufc_consts.vh
// Constants for the UART channel register set and receiver timing
// How it works
// - Enhanced feature and flow characters reachable only when format control is 0xBF.
// - Divisor latches reachable only while format control bit 7 is set.
// - Transmit holding write loads bus data only when holding register empty, or FIFO not full.
// - Holding-empty flag set when holding register empty; FIFO mode means free space.
// - Each receive holding read returns oldest character and pops it.
// - Start edge counted on 16x ticks; sampled mid-bit, rejected if high.
// - Receive interrupt and source flag follow fill at or above trigger.
// - Data ready set on character into FIFO, cleared only when empty.
// - FIFOs on with mask bits 0-3 clear gives polled operation; here mask bits 5-7, with feature bit 4 set, still raise irq.
// - Line status reports errors 1-4, tx empty 5, all empty 6, fifo error 7.
// - Mask bit 1 raises transmitter-empty interrupt while holding empty.
// - Mask bit 2 raises line status interrupt per assembled character.
// - Mask bits 6 and 7 interrupt on RTS and CTS rising transitions.
// - Mask bit 4 sleep, bit 5 pause interrupt; all mask bits reset zero.
// - Feature bit 4 gates enhanced mask, source, fifo and modem bits.
// - FIFO control bit 0 enables FIFOs; other bits need it in same write.
// - FIFO control bits 1 and 2 flush that FIFO and self-clear.
// - FIFO control bit 3 selects ready mode 0 or 1.
// - Mode 0: tx ready low when holding empty, rx ready when data held.
// - Mode 1: tx ready low while space; tx interrupt below tx trigger.
// - Mode 1: rx interrupt at trigger; rx ready low from trigger until empty.
// - Ready summary gives rx ready D-A high nibble, tx low, by select pin.
// - Receive trigger codes 00-11 pick 8, 16, 56, 60; default 8.
`ifndef UFC_CONSTS_VH
`define UFC_CONSTS_VH
`define UFC_A_DATA    3'h0
`define UFC_A_MASK    3'h1
`define UFC_A_FIFO    3'h2
`define UFC_A_FMT     3'h3
`define UFC_A_MODEM   3'h4
`define UFC_A_LSTAT   3'h5
`define UFC_A_MSTAT   3'h6
`define UFC_A_SCRATCH 3'h7
`define UFC_A_FEAT    3'h2
`define UFC_A_RES_LO  3'h4
`define UFC_A_RES_HI  3'h5
`define UFC_A_PAU_LO  3'h6
`define UFC_A_PAU_HI  3'h7
`define UFC_ENH_KEY   8'hBF
`define UFC_DLAB_BIT  7
`define UFC_FEAT_ENH  4
`define UFC_RST_REG   8'h00
`define UFC_RST_SCR   8'hFF
`define UFC_RST_DIV   16'h0001
`define UFC_TRIG_8    7'h08
`define UFC_TRIG_16   7'h10
`define UFC_TRIG_32   7'h20
`define UFC_TRIG_56   7'h38
`define UFC_TRIG_60   7'h3C
`define UFC_TICKS_BIT 4'hF
`define UFC_START_MID 4'h7
`define UFC_DATA_BITS 3'h7
`define UFC_ISR_NONE  6'h01
`define UFC_ISR_LINE  6'h06
`define UFC_ISR_RXD   6'h04
`define UFC_ISR_TXE   6'h02
`define UFC_ISR_PAUSE 6'h10
`define UFC_ISR_FLOW  6'h20
`endif

// ===== core/ufc_fifo.v
// Flip-flop FIFO with valid/ready on both sides, flush and fill count
`timescale 1ns/1ps
module ufc_fifo #(
  parameter W  = 8,
  parameter D  = 64,
  parameter AW = 6
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          resetn,
  // Control
  input  wire          flush,
  input  wire          one_deep,
  // Fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // Drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  output wire [AW:0]   count
);
  reg [W-1:0]  mem_ff [0:D-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0]   cnt_ff;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  localparam [AW:0] FULL = D;
  localparam [AW:0] ONE  = 1;
  // One-deep mode stands in for a lone holding register
  assign in_ready  = one_deep ? (cnt_ff == {(AW+1){1'b0}}) : (cnt_ff != FULL);
  assign out_valid = cnt_ff != {(AW+1){1'b0}};
  assign out_data  = mem_ff[rd_ff];
  assign count     = cnt_ff;
  always @(posedge ref_clk) begin
    if (push)
      mem_ff[wr_ff] <= in_data;
  end
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ff <= wr_ff + ONE[AW-1:0];
      if (pop)
        rd_ff <= rd_ff + ONE[AW-1:0];
      if (push & ~pop)
        cnt_ff <= cnt_ff + ONE;
      else if (pop & ~push)
        cnt_ff <= cnt_ff - ONE;
    end
  end
endmodule // ufc_fifo

// ===== verification/ufc_channel_monitor.sv
// Port checker for one UART channel
`timescale 1ns/1ps
module ufc_monitor (
  // Clock and reset
  input wire       ref_clk,
  input wire       resetn,
  // Host bus
  input wire       cs_n,
  input wire       rd_n,
  input wire       wr_n,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire       ready_summary_select_n,
  input wire [2:0] peer_rx_ready_n,
  input wire [2:0] peer_tx_ready_n,
  // Status pins
  input wire       irq,
  input wire       tx_ready_n,
  input wire       rx_ready_n,
  input wire       sleep_en
);
  reg  [7:0] fmt_ff;
  reg  [7:0] feat_ff;
  reg  [7:0] mask_ff;
  reg  [7:0] dl_ff;
  reg        mode_ff;
  wire       wr  = !cs_n && !wr_n;
  wire       rd  = !cs_n && !rd_n;
  wire       enh = fmt_ff == 8'hBF;
  wire       line_status = rd && !enh && addr == 3'h5;
  // Shadows; gated mask bits keep their old value
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fmt_ff  <= 8'h00;
      feat_ff <= 8'h00;
      mask_ff <= 8'h00;
      dl_ff   <= 8'h01;
      mode_ff <= 1'h0;
    end else if (wr) begin
      if (addr == 3'h3) fmt_ff <= wdata;
      if (enh && addr == 3'h2) feat_ff <= wdata;
      if (!enh && fmt_ff[7] && addr == 3'h0) dl_ff <= wdata;
      if (!enh && !fmt_ff[7] && addr == 3'h1)
        mask_ff <= {feat_ff[4] ? wdata[7:4] : mask_ff[7:4], wdata[3:0]};
      if (!enh && !fmt_ff[7] && addr == 3'h2)
        mode_ff <= wdata[0] & wdata[3];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  hold_rdata_a: assert property (
    rd_n |=> $stable(rdata)) else $error("rdata moved with no read");
  summary_byte_a: assert property (
    !ready_summary_select_n && !rd_n |=>
    rdata == {$past(peer_rx_ready_n), $past(rx_ready_n),
    $past(peer_tx_ready_n), $past(tx_ready_n)})
    else $error("ready summary byte wrong");
  feat_read_a: assert property (
    rd && enh && addr == 3'h2 |=> rdata == $past(feat_ff))
    else $error("feature register read wrong");
  div_read_a: assert property (
    rd && !enh && fmt_ff[7] && addr == 3'h0 |=> rdata == $past(dl_ff))
    else $error("divisor low read wrong");
  sleep_gate_a: assert property (
    wr && !enh && !fmt_ff[7] && addr == 3'h1 |=>
    sleep_en == ($past(wdata[4]) && feat_ff[4]))
    else $error("sleep enable not gated");
  polled_irq_a: assert property (
    mask_ff == 8'h00 |-> !irq) else $error("irq with all masked");
  lsr_rx_a: assert property (
    line_status && !mode_ff |=> rdata[0] == !$past(rx_ready_n))
    else $error("data ready disagrees with rx ready");
  lsr_tx_a: assert property (
    line_status && mode_ff |=> rdata[5] == !$past(tx_ready_n))
    else $error("tx space disagrees with tx ready");
  lsr_empty_a: assert property (
    line_status |=> !rdata[6] || rdata[5]) else $error("all empty but fifo not");
  cover property (!ready_summary_select_n && !rd_n);
  cover property (line_status && mode_ff);
  cover property ($rose(irq));
endmodule // ufc_monitor

bind ufc_channel ufc_monitor i_mon (.*);

// ===== verification/ufc_line_peer.sv
// Far-end serial sender driving the channel receive line
`timescale 1ns/1ps
module ufc_line_peer (
  // Clock
  input wire ref_clk,
  // Serial line
  input wire tx,
  output reg rx
);
  integer i;
  initial rx = 1'h1;
  // One frame at 16 clocks a bit, LSB first; idles high after stop
  task send(input [7:0] b);
    reg [9:0] f;
    begin
      f = {1'h1, b, 1'h0};
      for (i = 0; i < 160; i = i + 1) begin
        @(negedge ref_clk);
        rx = f[i/16];
      end
    end
  endtask
  // Low pulse too short to pass the mid-bit check
  task glitch(input integer n);
    begin
      @(negedge ref_clk);
      rx = 1'h0;
      repeat (n) @(negedge ref_clk);
      rx = 1'h1;
      // Stay idle past the mid-bit check so it really sees high
      repeat (16) @(negedge ref_clk);
    end
  endtask
  // Capture one frame from the channel output at mid-bit points
  task take(output [7:0] b);
    integer j;
    begin
      @(negedge tx);
      repeat (8) @(negedge ref_clk);
      for (j = 0; j < 8; j = j + 1) begin
        repeat (16) @(negedge ref_clk);
        b[j] = tx;
      end
    end
  endtask
endmodule // ufc_line_peer

// ===== verification/ufc_channel_tb.sv
// Self-checking bench for one UART channel
`timescale 1ns/1ps
module ufc_channel_tb;
  reg        ref_clk, resetn, cs_n, rd_n, wr_n, sum_n, cts_n;
  reg  [2:0] addr, prx, ptx;
  reg  [7:0] wdata, got, rxb;
  wire [7:0] rdata;
  wire       rx, tx, rts_n, dtr_n, irq, tx_ready_n, rx_ready_n, sleep_en;
  integer    n_fail, checks_done, k;
  ufc_channel i_dut (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata), .rdata(rdata),
    .ready_summary_select_n(sum_n), .peer_rx_ready_n(prx),
    .peer_tx_ready_n(ptx), .rx(rx), .tx(tx), .cts_n(cts_n), .rts_n(rts_n),
    .dtr_n(dtr_n), .irq(irq), .tx_ready_n(tx_ready_n),
    .rx_ready_n(rx_ready_n), .sleep_en(sleep_en));
  ufc_line_peer i_peer (.ref_clk(ref_clk), .tx(tx), .rx(rx));
  task chk(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(negedge ref_clk);
      cs_n = 1'h0;
      wr_n = 1'h0;
      addr = a;
      wdata = d;
      @(negedge ref_clk);
      cs_n = 1'h1;
      wr_n = 1'h1;
    end
  endtask
  // Summary reads use the select pin in place of chip select
  task rd(input [2:0] a, input s);
    begin
      @(negedge ref_clk);
      cs_n = s;
      sum_n = !s;
      rd_n = 1'h0;
      addr = a;
      @(negedge ref_clk);
      cs_n = 1'h1;
      sum_n = 1'h1;
      rd_n = 1'h1;
      got = rdata;
    end
  endtask
  task rc(input [2:0] a, input [7:0] e);
    begin
      rd(a, 1'h0);
      chk(got, e);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // About 2000 cycles expected
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail = n_fail + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out;
  end
  initial begin
    {n_fail, checks_done} = 0;
    {resetn, addr, wdata} = 0;
    {cs_n, rd_n, wr_n, sum_n, cts_n} = 5'h1F;
    prx = 3'h5;
    ptx = 3'h2;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'h1;
    chk({6'h00, tx_ready_n, rx_ready_n}, 8'h01);
    rc(3'h1, 8'h00);
    rc(3'h5, 8'h60);
    wr(3'h1, 8'h10);
    chk({7'h00, sleep_en}, 8'h00);
    wr(3'h3, 8'hBF);
    rc(3'h2, 8'h00);
    wr(3'h2, 8'h10);
    wr(3'h4, 8'h11);
    rc(3'h4, 8'h11);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rc(3'h0, 8'h01);
    rc(3'h4, 8'h00);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h12);
    chk({6'h00, sleep_en, irq}, 8'h03);
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rc(3'h2, 8'hC1);
    i_peer.glitch(4);
    i_peer.send(8'hA5);
    i_peer.send(8'h3C);
    repeat (4) @(negedge ref_clk);
    wr(3'h1, 8'h04);
    chk({7'h00, irq}, 8'h01);
    rc(3'h5, 8'h61);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, rx_ready_n}, 8'h00);
    rc(3'h0, 8'hA5);
    rc(3'h0, 8'h3C);
    rc(3'h5, 8'h60);
    wr(3'h2, 8'h08);
    rc(3'h2, 8'h01);
    wr(3'h2, 8'h09);
    wr(3'h1, 8'h01);
    for (k = 0; k < 8; k = k + 1) begin
      chk({6'h00, irq, rx_ready_n}, 8'h01);
      i_peer.send(k[7:0]);
    end
    repeat (4) @(negedge ref_clk);
    chk({6'h00, irq, rx_ready_n}, 8'h02);
    rc(3'h2, 8'hC4);
    rc(3'h0, 8'h00);
    chk({6'h00, irq, rx_ready_n}, 8'h00);
    wr(3'h2, 8'h0B);
    rc(3'h5, 8'h60);
    fork
      i_peer.take(rxb);
      begin
        wr(3'h0, 8'h55);
        rc(3'h5, 8'h20);
      end
    join
    chk(rxb, 8'h55);
    repeat (200) @(negedge ref_clk);
    rc(3'h5, 8'h60);
    wr(3'h1, 8'hC0);
    wr(3'h4, 8'h03);
    @(negedge ref_clk);
    chk({5'h00, rts_n, dtr_n, irq}, 8'h01);
    rc(3'h2, 8'hE0);
    chk({7'h00, irq}, 8'h00);
    @(negedge ref_clk);
    cts_n = 1'h0;
    @(negedge ref_clk);
    chk({7'h00, irq}, 8'h01);
    rd(3'h0, 1'h1);
    chk(got, 8'hB4);
    close_out;
  end
endmodule // ufc_channel_tb
